// File: bench/vdp_divider_pfd_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "vdp_defs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %0h got %0h", n, e, s); end end
module vdp_divider_pfd_bench;
    logic       clk = 0;
    logic       resetn = 0;
    logic [9:0] mainRatio = 10'h008;
    logic [6:0] swallowRatio = 7'h00;
    logic       loadStrobe = 0;
    logic       refPulse = 0;
    wire        modSel, divOut, coarse, oe, lockN;
    wire  [7:0] fine;
    int         vcoCount, lowCount, miscompares, n_checks, lead, phase;
    always #50 clk = ~clk;
    // Reference high 8 clocks, rising lead clocks before each divider pulse
    always @(negedge clk)
    begin
        phase = divOut ? 1 : phase + 1;
        refPulse <= (lead != 0) && (((phase + lead) % mainRatio) < 8);
    end
    vdp_divider_pfd dut (.clk(clk), .resetn(resetn), .mainRatio(mainRatio),
        .swallowRatio(swallowRatio), .loadStrobe(loadStrobe),
        .refPulse(refPulse), .modulus_select_out(modSel), .divOut(divOut),
        .coarse_error_out(coarse), .coarseErrorOe(oe),
        .lock_indicator_n(lockN), .fine_error_out(fine));
    vdp_prescaler_model #(.P(8)) pre (.clk(clk), .resetn(resetn),
        .modSel(modSel), .divOut(divOut), .vcoCount(vcoCount),
        .lowCount(lowCount));
    task automatic give_verdict(int bad);
        miscompares += bad;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic waitDiv;
        int k;
        for (k = 0; k < 2100 && !divOut; k++)
            @(negedge clk);
        @(negedge clk);
        if (k == 2100)
            give_verdict(1);
    endtask
    task automatic checkRatio(int m, int a);
        mainRatio = 10'h3ff;
        loadStrobe = 1;
        @(negedge clk);
        mainRatio = m[9:0];
        swallowRatio = a[6:0];
        @(negedge clk);
        loadStrobe = 0;
        repeat (3) waitDiv;
        `CHK("vco", m * 8 + a, vcoCount)
        `CHK("lows", a, lowCount)
    endtask
    // Detector restarted gap clocks after a divider pulse: first edge known
    task automatic checkLock(int ld, int gap, logic expN, logic dir);
        int k;
        waitDiv;
        lead = ld;
        repeat (2) waitDiv;
        repeat (gap) @(negedge clk);
        loadStrobe = 1;
        @(negedge clk);
        loadStrobe = 0;
        repeat (400) @(negedge clk);
        for (k = 0; k < 4000 && lockN !== expN; k++)
            @(negedge clk);
        `CHK("lockN", expN, lockN)
        `CHK("oe", expN, oe)
        if (expN)
            `CHK("dir", dir, coarse)
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        `CHK("rst", 12'hc80, {lockN, oe, divOut, modSel, fine})
        resetn = 1;
        checkRatio(8, 0);
        checkRatio(8, 8);
        checkRatio(100, 37);
        checkRatio(1023, 127);
        checkRatio(40, 3);
        checkLock(30, 20, 1, `VDP_ERR_DOWN);
        checkLock(12, 0, 1, `VDP_ERR_UP);
        checkLock(1, 0, 0, 1'b0);
        checkLock(30, 0, 1, `VDP_ERR_UP);
        checkLock(3, 0, 0, 1'b0);
        give_verdict(0);
    end
endmodule
`default_nettype wire

// File: bench/vdp_divider_pfd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module vdp_divider_pfd_checker #(parameter RAMP_W = 8)(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              divOut,
    input wire logic              coarseErrorOe,
    input wire logic              lock_indicator_n,
    input wire logic [RAMP_W-1:0] fine_error_out
);
    // Cycles since the last divider pulse, saturating
    logic [10:0] gapCnt;
    always @(posedge clk or negedge resetn)
        if (!resetn)
            gapCnt <= 11'h000;
        else if (divOut)
            gapCnt <= 11'h001;
        else if (gapCnt != 11'h7ff)
            gapCnt <= gapCnt + 11'h001;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_lock_tracks_oe: assert property (
        lock_indicator_n == coarseErrorOe) else $error("lock vs enable");
    a_lock_on_release: assert property (
        $fell(coarseErrorOe) |-> $fell(lock_indicator_n))
        else $error("lock late");
    a_unlock_on_drive: assert property (
        $rose(coarseErrorOe) |-> $rose(lock_indicator_n))
        else $error("unlock late");
    a_div_one_pulse: assert property (
        divOut |=> !divOut [*7]) else $error("divider cycle short");
    a_div_period_max: assert property (
        gapCnt <= 11'h3ff) else $error("divider cycle long");
    a_fine_per_ref: assert property (
        $changed(fine_error_out) |=> $stable(fine_error_out) [*6])
        else $error("ramp sampled twice");
    a_reset_unlocked: assert property (
        $rose(resetn) |-> lock_indicator_n && coarseErrorOe && !divOut)
        else $error("reset state");
    a_reset_ramp_mid: assert property (
        $rose(resetn) |-> fine_error_out == {1'b1, {(RAMP_W-1){1'b0}}})
        else $error("ramp reset");
endmodule
bind vdp_divider_pfd vdp_divider_pfd_checker #(.RAMP_W(RAMP_W)) chk (
    .clk(clk), .resetn(resetn), .divOut(divOut),
    .coarseErrorOe(coarseErrorOe), .lock_indicator_n(lock_indicator_n),
    .fine_error_out(fine_error_out));
`default_nettype wire

// File: bench/vdp_prescaler_model.sv
`timescale 1ns/1ns
`default_nettype none
// Prescaler: P+1 while select low, P while high; sums per cycle
module vdp_prescaler_model #(parameter int P = 8)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic modSel,
    input wire logic divOut,
    output var int   vcoCount,
    output var int   lowCount
);
    int acc;
    int low;
    always @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            acc <= 0;
            low <= 0;
        end
        else if (divOut)
        begin
            vcoCount <= acc + (modSel ? P : P + 1);
            lowCount <= low + (modSel ? 0 : 1);
            acc <= 0;
            low <= 0;
        end
        else
        begin
            acc <= acc + (modSel ? P : P + 1);
            low <= low + (modSel ? 0 : 1);
        end
endmodule
`default_nettype wire

// File: hw/vdp_defs.vh
`ifndef VDP_DEFS_VH
`define VDP_DEFS_VH

// Counter widths
`define VDP_MAIN_W       10
`define VDP_SWAL_W       7
// Programming ranges
`define VDP_MAIN_MIN     10'h008
`define VDP_MAIN_MAX     10'h3ff
`define VDP_SWAL_MAX     7'h7f
// Reset values of the ratio latches
`define VDP_MAIN_RST     10'h008
`define VDP_SWAL_RST     7'h00
// Default fine window in clock cycles and ramp width in bits
`define VDP_WINDOW_DEF   4
`define VDP_RAMP_W       8
// Coarse error output levels
`define VDP_ERR_UP       1'b1
`define VDP_ERR_DOWN     1'b0

`endif

// File: hw/vdp_divider_pfd.v
// Summary of operation
// - Total division is main count times prescaler modulus plus swallow count.
// - Main ratio is 8 to 1023; loads outside that range are not supported.
// - Swallow ratio is 0 to 127 and must not exceed the main ratio.
// - A digital phase/frequency detector drives a three-state coarse error.
// - Coarse error is driven outside the fine window and released inside it.
// - The active-low lock indicator falls when coarse error is released.
// - Edges of both dividers steer a ramp sampled once per reference period.
// - Modulus select is low until swallow ends, then high until main ends.
// - Swallow is a 7-bit word and main a 10-bit word, loaded in parallel on loadStrobe.
// - A ratio load clears the phase detector flags and the fine ramp; the divider counters are not restarted.
`timescale 1ns/1ns
`default_nettype none
`include "vdp_defs.vh"

module vdp_divider_pfd #(
    parameter MAIN_W = `VDP_MAIN_W,
    parameter SWAL_W = `VDP_SWAL_W,
    parameter WINDOW = `VDP_WINDOW_DEF,
    parameter RAMP_W = `VDP_RAMP_W
)(
    input  wire              clk,
    input  wire              resetn,
    input  wire [MAIN_W-1:0] mainRatio,
    input  wire [SWAL_W-1:0] swallowRatio,
    input  wire              loadStrobe,
    input  wire              refPulse,
    output reg               modulus_select_out,
    output reg               divOut,
    output reg               coarse_error_out,
    output reg               coarseErrorOe,
    output reg               lock_indicator_n,
    output reg  [RAMP_W-1:0] fine_error_out
);

    // Ratio latches and counters
    reg  [MAIN_W-1:0] mainLatch;
    reg  [SWAL_W-1:0] swalLatch;
    reg  [MAIN_W-1:0] mainCnt;
    reg  [SWAL_W-1:0] swalCnt;
    wire              cycleEnd;
    wire              swalDone;

    // Reference input synchroniser
    reg  [2:0]        refSync;
    reg               refLevel;
    wire              refEdge;

    // Phase detector state
    reg               upFlag;
    reg               downFlag;
    reg  [RAMP_W-1:0] ramp;
    reg  [RAMP_W-1:0] errWidth;
    reg  [RAMP_W-1:0] next_errWidth;
    wire [RAMP_W-1:0] episodeWidth;

    function [RAMP_W-1:0] satInc;
        input [RAMP_W-1:0] v;
        begin
            satInc = (&v) ? v : v + {{(RAMP_W-1){1'b0}}, 1'b1};
        end
    endfunction

    assign cycleEnd = (mainCnt == {{(MAIN_W-1){1'b0}}, 1'b1});
    assign swalDone = (swalCnt == {SWAL_W{1'b0}});

    // Three-stage sync, edge counts when stages two and three agree
    assign refEdge = (refSync[2] == refSync[1]) && refSync[2] && !refLevel;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            refSync  <= 3'h0;
            refLevel <= 1'b0;
        end
        else
        begin
            refSync <= {refSync[1:0], refPulse};
            if (refSync[2] == refSync[1])
                refLevel <= refSync[2];
        end
    end

    // Latch newly programmed ratios
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mainLatch   <= `VDP_MAIN_RST;
            swalLatch   <= `VDP_SWAL_RST;
        end
        else if (loadStrobe)
        begin
            mainLatch   <= mainRatio;
            swalLatch   <= swallowRatio;
        end
    end

    // Dual-modulus counting: swallow phase low, main-only phase high
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mainCnt            <= `VDP_MAIN_RST;
            swalCnt            <= `VDP_SWAL_RST;
            modulus_select_out <= 1'b0;
            divOut             <= 1'b0;
        end
        else if (cycleEnd)
        begin
            mainCnt            <= mainLatch;
            swalCnt            <= swalLatch;
            modulus_select_out <= (swalLatch == {SWAL_W{1'b0}});
            divOut             <= 1'b1;
        end
        else
        begin
            mainCnt <= mainCnt - {{(MAIN_W-1){1'b0}}, 1'b1};
            divOut  <= 1'b0;
            if (!swalDone)
                swalCnt <= swalCnt - {{(SWAL_W-1){1'b0}}, 1'b1};
            modulus_select_out <= (swalCnt <= {{(SWAL_W-1){1'b0}}, 1'b1});
        end
    end

    // Phase/frequency detector, cleared on ratio load
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            upFlag   <= 1'b0;
            downFlag <= 1'b0;
        end
        else if (loadStrobe)
        begin
            upFlag   <= 1'b0;
            downFlag <= 1'b0;
        end
        else
        begin
            if ((upFlag || refEdge) && (downFlag || cycleEnd))
            begin
                upFlag   <= 1'b0;
                downFlag <= 1'b0;
            end
            else
            begin
                upFlag   <= upFlag | refEdge;
                downFlag <= downFlag | cycleEnd;
            end
        end
    end

    // Width of the episode that ends at this edge
    assign episodeWidth = (upFlag || downFlag) ? next_errWidth : errWidth;

    // Episode width, cleared when a detector episode opens
    always @*
    begin
        next_errWidth = errWidth;
        if (!(upFlag || downFlag) && (refEdge || cycleEnd))
            next_errWidth = {RAMP_W{1'b0}};
        else if (upFlag || downFlag)
            next_errWidth = satInc(errWidth);
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            errWidth <= {RAMP_W{1'b0}};
        else
            errWidth <= next_errWidth;
    end

    // Fine ramp restarts on each divider pulse, sampled on reference edge
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ramp           <= {RAMP_W{1'b0}};
            fine_error_out <= {1'b1, {(RAMP_W-1){1'b0}}};
        end
        else
        begin
            if (cycleEnd || loadStrobe)
                ramp <= {RAMP_W{1'b0}};
            else
                ramp <= satInc(ramp);
            if (refEdge)
                fine_error_out <= ramp;
        end
    end

    // Coarse direction holds the last pump request
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            coarse_error_out <= `VDP_ERR_DOWN;
        else if (upFlag)
            coarse_error_out <= `VDP_ERR_UP;
        else if (downFlag)
            coarse_error_out <= `VDP_ERR_DOWN;
    end

    // Drive and lock follow the width of the last episode
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            coarseErrorOe    <= 1'b1;
            lock_indicator_n <= 1'b1;
        end
        else if (errWidth > WINDOW[RAMP_W-1:0])
        begin
            coarseErrorOe    <= 1'b1;
            lock_indicator_n <= 1'b1;
        end
        else if (refEdge && (episodeWidth <= WINDOW[RAMP_W-1:0]))
        begin
            coarseErrorOe    <= 1'b0;
            lock_indicator_n <= 1'b0;
        end
    end

endmodule
`default_nettype wire
